// *** core/tsense_pkg.sv ***
// shared constants, types and crc helper for the sensor serial port
package tsense_pkg;

    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned MS_CYCLES_DEF  = CLK_HZ / MS_PER_S;
    localparam int unsigned SCL_LOW_MIN_MS = 20;
    localparam int unsigned SCL_LOW_MAX_MS = 45;
    // one extra tick covers the unknown phase of the millisecond divider
    localparam int unsigned SCL_LOW_RESET_INTERVAL = SCL_LOW_MIN_MS + 1;
    localparam logic [5:0]  TO_TICKS = 6'(SCL_LOW_RESET_INTERVAL);

    localparam logic [6:0]  ADDR_BASE  = 7'h48;
    localparam int unsigned ADDR_LOW_W = 3;
    localparam logic [7:0]  SEL_TEMP   = 8'h00;
    localparam logic [7:0]  CRC_POLY   = 8'h07;
    localparam logic [7:0]  CRC_INIT   = 8'h00;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;

    localparam logic [3:0]  RX_LAST = 4'h8;
    localparam logic [3:0]  TX_LAST = 4'h7;

    localparam logic [1:0]  IDX_ADDR = 2'h0;
    localparam logic [1:0]  IDX_SEL  = 2'h1;
    localparam logic [1:0]  IDX_DATA = 2'h2;

    localparam logic [1:0]  PH_HI  = 2'h0;
    localparam logic [1:0]  PH_LO  = 2'h1;
    localparam logic [1:0]  PH_PEC = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h3,
        ST_TX   = 3'h2,
        ST_RACK = 3'h6
    } port_state_t;

    typedef struct packed {
        logic [7:0]  sel;
        logic [15:0] data;
        logic        hi_only;
    } wr_t;

    function automatic logic [7:0] crc8(input logic [7:0] crc,
                                        input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// *** core/bit_sync.sv ***
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta   <= '1;
            sync_o <= '1;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// *** core/tsense_port.sv ***
// two-wire target port of the temperature sensor
// Notes on behaviour
// - scl low past the reset interval resets the port and releases sda
// - temperature result held steady while it is being read
// - pending measurement loaded once the temperature read is over
// - write is address, selector, high, low, each acknowledged, then stop
// - without pec, extra pairs overwrite the same register
// - with pec, writes not a multiple of three data bytes are dropped
// - later pec bytes cover every earlier byte including earlier pec
// - read is selector write, repeated start, address read, high, low
// - with pec, device sends a pec byte after the low byte
// - answers only its own address from the fixed upper-bit range
// - timeout and pec are enabled separately
// - timeout is on while the disable input is low
// - without pec, a single data byte lands in the upper byte
// - extra read bytes come from the same register
`timescale 1ns/1ps
module tsense_port #(
    parameter logic [2:0]  ADDR_LOW  = 3'h0,
    parameter int unsigned MS_CYCLES = tsense_pkg::MS_CYCLES_DEF
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe_n_o,
    input  wire logic         pec_en_i,
    input  wire logic         timeout_dis_i,
    input  wire logic [15:0]  temp_i,
    input  wire logic         temp_valid_i,
    input  wire logic [15:0]  rd_data_i,
    output logic      [15:0]  temp_o,
    output logic      [7:0]   sel_o,
    output tsense_pkg::wr_t   wr_o,
    output logic              wr_stb_o
);
    localparam int MSW = $clog2(MS_CYCLES);
    localparam logic [6:0] OWN_ADDR = {
        tsense_pkg::ADDR_BASE[6:tsense_pkg::ADDR_LOW_W], ADDR_LOW};

    ////////////////////////////////////////////////////////////////////
    logic [1:0] pins;
    logic       scl_s;
    logic       sda_s;
    logic       scl_q;
    logic       sda_q;

    bit_sync #(.WIDTH(2)) u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    ({scl_i, sda_i}),
        .sync_o     (pins)
    );
    assign scl_s = pins[1];
    assign sda_s = pins[0];

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    // start and stop framing
    // start detection
    assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    ////////////////////////////////////////////////////////////////////
    // millisecond tick divider
    logic [MSW-1:0] ms_cnt;
    logic [5:0]     to_cnt;
    logic           ms_tick;
    logic           to_fire;
    assign ms_tick = (ms_cnt == MSW'(MS_CYCLES - 1));
    assign to_fire = (to_cnt == tsense_pkg::TO_TICKS);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ms_cnt <= '0;
            to_cnt <= '0;
        end else begin
            ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
            // disable input set or scl high clears the count
            if (timeout_dis_i || scl_s || to_fire) begin
                to_cnt <= '0;
            end else if (ms_tick) begin
                to_cnt <= to_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    tsense_pkg::port_state_t state;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  crc;
    logic [1:0]  rx_idx;
    logic [1:0]  ph;
    logic [1:0]  rd_ph;
    logic [7:0]  pend_hi;
    logic [15:0] cand;
    logic [15:0] pair;
    logic        pair_v;
    logic        pec_ok;
    logic        is_rd;
    logic        busy;
    logic        byte_in;
    logic        addr_hit;
    logic        finish;
    logic        load_tx;
    logic [15:0] src;
    logic [7:0]  next_tx;
    logic [7:0]  crc_in;

    assign byte_in  = scl_fall && state == tsense_pkg::ST_RX
                      && bit_cnt == tsense_pkg::RX_LAST;
    assign addr_hit = rx_sh[7:1] == OWN_ADDR;
    assign finish   = stop_c | (start_c & busy);
    assign load_tx  = scl_fall && is_rd && (state == tsense_pkg::ST_ACK
                      || state == tsense_pkg::ST_RACK);
    assign crc_in   = tsense_pkg::crc8(crc, rx_sh);
    // same register for every read byte but the pec byte
    assign src      = (sel_o == tsense_pkg::SEL_TEMP) ? temp_o : rd_data_i;
    assign next_tx  = (rd_ph == tsense_pkg::PH_HI) ? src[15:8] :
                      (rd_ph == tsense_pkg::PH_LO) ? src[7:0] : crc;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state      <= tsense_pkg::ST_IDLE;
            bit_cnt    <= '0;
            rx_sh      <= '0;
            tx_sh      <= '0;
            sda_oe_n_o <= 1'b1;
            sda_o      <= 1'b0;
            rx_idx     <= tsense_pkg::IDX_ADDR;
            is_rd      <= 1'b0;
            busy       <= 1'b0;
            rd_ph      <= tsense_pkg::PH_HI;
        end else if (to_fire) begin
            state      <= tsense_pkg::ST_IDLE;
            sda_oe_n_o <= 1'b1;
            is_rd      <= 1'b0;
            busy       <= 1'b0;
            rx_idx     <= tsense_pkg::IDX_ADDR;
        end else if (start_c) begin
            state      <= tsense_pkg::ST_RX;
            bit_cnt    <= '0;
            sda_oe_n_o <= 1'b1;
            rx_idx     <= tsense_pkg::IDX_ADDR;
            is_rd      <= 1'b0;
            busy       <= 1'b1;
        end else if (stop_c) begin
            state      <= tsense_pkg::ST_IDLE;
            sda_oe_n_o <= 1'b1;
            is_rd      <= 1'b0;
            busy       <= 1'b0;
        end else if (scl_rise) begin
            if (state == tsense_pkg::ST_RX) begin
                rx_sh   <= {rx_sh[6:0], sda_s};
                bit_cnt <= bit_cnt + 1'b1;
            end else if (state == tsense_pkg::ST_RACK && sda_s) begin
                // master nack ends the data phase
                state <= tsense_pkg::ST_IDLE;
            end
        end else if (scl_fall) begin
            case (state)
                tsense_pkg::ST_RX: begin
                    if (byte_in) begin
                        state      <= tsense_pkg::ST_ACK;
                        sda_oe_n_o <= 1'b0;
                        if (rx_idx == tsense_pkg::IDX_ADDR) begin
                            if (!addr_hit) begin
                                state      <= tsense_pkg::ST_IDLE;
                                sda_oe_n_o <= 1'b1;
                            end else begin
                                is_rd  <= rx_sh[0];
                                rx_idx <= tsense_pkg::IDX_SEL;
                                rd_ph  <= tsense_pkg::PH_HI;
                            end
                        end else if (rx_idx == tsense_pkg::IDX_SEL) begin
                            rx_idx <= tsense_pkg::IDX_DATA;
                        end
                    end
                end
                tsense_pkg::ST_ACK, tsense_pkg::ST_RACK: begin
                    // read data follows the address ack
                    if (is_rd) begin
                        state      <= tsense_pkg::ST_TX;
                        tx_sh      <= next_tx;
                        sda_oe_n_o <= next_tx[7];
                        bit_cnt    <= '0;
                        // pec slot after the low byte
                        if (rd_ph == tsense_pkg::PH_HI) begin
                            rd_ph <= tsense_pkg::PH_LO;
                        end else if (rd_ph == tsense_pkg::PH_LO
                                     && pec_en_i) begin
                            rd_ph <= tsense_pkg::PH_PEC;
                        end else begin
                            rd_ph <= tsense_pkg::PH_HI;
                        end
                    end else begin
                        state      <= tsense_pkg::ST_RX;
                        sda_oe_n_o <= 1'b1;
                        bit_cnt    <= '0;
                    end
                end
                tsense_pkg::ST_TX: begin
                    if (bit_cnt == tsense_pkg::TX_LAST) begin
                        state      <= tsense_pkg::ST_RACK;
                        sda_oe_n_o <= 1'b1;
                    end else begin
                        tx_sh      <= {tx_sh[6:0], 1'b0};
                        sda_oe_n_o <= tx_sh[6];
                        bit_cnt    <= bit_cnt + 1'b1;
                    end
                end
                default: begin
                    sda_oe_n_o <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data byte tracking, selector and pec running value
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc     <= tsense_pkg::CRC_INIT;
            sel_o   <= tsense_pkg::SEL_TEMP;
            ph      <= tsense_pkg::PH_HI;
            pend_hi <= '0;
            cand    <= '0;
            pair    <= '0;
            pair_v  <= 1'b0;
            pec_ok  <= 1'b1;
        end else if (start_c || to_fire) begin
            // repeated start keeps the running pec
            if (!busy || to_fire) begin
                crc <= tsense_pkg::CRC_INIT;
            end
            ph     <= tsense_pkg::PH_HI;
            pair_v <= 1'b0;
            pec_ok <= 1'b1;
        end else if (byte_in && (rx_idx != tsense_pkg::IDX_ADDR
                                 || addr_hit)) begin
            // crc over every byte in bus order
            crc <= crc_in;
            if (rx_idx == tsense_pkg::IDX_SEL) begin
                sel_o <= rx_sh;
            end else if (rx_idx == tsense_pkg::IDX_DATA) begin
                case (ph)
                    tsense_pkg::PH_HI: begin
                        pend_hi <= rx_sh;
                        ph      <= tsense_pkg::PH_LO;
                    end
                    tsense_pkg::PH_LO: begin
                        cand <= {pend_hi, rx_sh};
                        if (pec_en_i) begin
                            ph <= tsense_pkg::PH_PEC;
                        end else begin
                            ph     <= tsense_pkg::PH_HI;
                            pair   <= {pend_hi, rx_sh};
                            pair_v <= 1'b1;
                        end
                    end
                    default: begin
                        ph <= tsense_pkg::PH_HI;
                        if (crc_in == tsense_pkg::BYTE_ZERO) begin
                            pair   <= cand;
                            pair_v <= 1'b1;
                        end else begin
                            pec_ok <= 1'b0;
                        end
                    end
                endcase
            end
        end else if (load_tx) begin
            crc <= tsense_pkg::crc8(crc, next_tx);
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic in_write;
    logic commit_pair;
    logic commit_hi;
    assign in_write    = !is_rd && rx_idx == tsense_pkg::IDX_DATA;
    // with pec, only complete checked groups are kept
    assign commit_pair = in_write && pair_v && (!pec_en_i
                         || (ph == tsense_pkg::PH_HI && pec_ok));
    assign commit_hi   = in_write && !pec_en_i && !pair_v
                         && ph == tsense_pkg::PH_LO;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_o     <= '0;
            wr_stb_o <= 1'b0;
        end else begin
            wr_stb_o <= finish && (commit_pair || commit_hi);
            if (finish && commit_pair) begin
                wr_o <= '{sel: sel_o, data: pair, hi_only: 1'b0};
            end else if (finish && commit_hi) begin
                // single byte goes to the upper half
                wr_o <= '{sel: sel_o, data: {pend_hi, tsense_pkg::BYTE_ZERO},
                          hi_only: 1'b1};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic        rd_temp;
    logic [15:0] pend;
    logic        pend_v;
    assign rd_temp = is_rd && sel_o == tsense_pkg::SEL_TEMP;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_o <= '0;
            pend   <= '0;
            pend_v <= 1'b0;
        end else if (rd_temp) begin
            if (temp_valid_i) begin
                pend   <= temp_i;
                pend_v <= 1'b1;
            end
        end else if (temp_valid_i) begin
            temp_o <= temp_i;
            pend_v <= 1'b0;
        end else if (pend_v) begin
            // load parked value after the read
            temp_o <= pend;
            pend_v <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_addr_byte;
        byte_in && rx_idx == tsense_pkg::IDX_ADDR;
    endsequence
    sequence s_released;
        sda_oe_n_o && state == tsense_pkg::ST_IDLE;
    endsequence

    a_timeout_release: assert property (
        to_fire |=> s_released
    ) else $error("timeout left sda driven");
    a_temp_frozen: assert property (
        rd_temp && $past(rd_temp) |-> $stable(temp_o)
    ) else $error("temperature changed during read");
    a_temp_reload: assert property (
        !rd_temp && pend_v && !temp_valid_i |=> temp_o == $past(pend)
    ) else $error("parked temperature not loaded");
    a_addr_miss: assert property (
        s_addr_byte ##0 !addr_hit |=> s_released ##1 sda_oe_n_o
    ) else $error("foreign address answered");
    a_addr_ack: assert property (
        s_addr_byte ##0 addr_hit |=> !sda_oe_n_o
                                 && state == tsense_pkg::ST_ACK
    ) else $error("own address not acknowledged");
    a_pec_drop: assert property (
        finish && pec_en_i && ph != tsense_pkg::PH_HI |=> !wr_stb_o
    ) else $error("incomplete pec write committed");
    a_single_hi: assert property (
        finish && commit_hi |=> wr_stb_o && wr_o.hi_only
                                && wr_o.data[7:0] == tsense_pkg::BYTE_ZERO
    ) else $error("single byte not placed high");
    a_pec_sent: assert property (
        load_tx && rd_ph == tsense_pkg::PH_PEC |=> tx_sh == $past(crc)
    ) else $error("read pec byte wrong");
    a_timeout_off: assert property (
        timeout_dis_i |=> to_cnt == '0
    ) else $error("timeout counted while disabled");
    a_read_sel: assert property (
        is_rd && $past(is_rd) |-> $stable(sel_o)
    ) else $error("selector moved during read");
endmodule

// *** tb/bus_master_model.sv ***
// behavioural two-wire bus master for the sensor port
`timescale 1ns/1ps
module bus_master_model (
    output logic      scl_o,
    output logic      pull_o,
    input  wire logic sda_i
);
    initial begin
        scl_o  = 1'b1;
        pull_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // crc-8 poly 07 from zero
    function automatic logic [7:0] crc_next(input logic [7:0] c,
                                            input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        repeat (8) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
        return x;
    endfunction

    task automatic start();
        pull_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 pull_o = 1'b1;
        #100 scl_o = 1'b0;
        #25;
    endtask

    // one scl clock, data set in low phase, sampled late in high phase
    task automatic clk_bit(input logic b, output logic r);
        pull_o = ~b;
        #100 scl_o = 1'b1;
        #70 r = sda_i;
        #5 scl_o = 1'b0;
        #25;
    endtask

    // msb first, ninth clock samples the ack
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    // ack all bytes but the last
    task automatic read_byte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            b[i] = r;
        end
        clk_bit(~mack, r);
    endtask

    task automatic stop();
        pull_o = 1'b1;
        #100 scl_o = 1'b1;
        #100 pull_o = 1'b0;
        #200;
    endtask
endmodule

// *** tb/tsense_port_bench.sv ***
// self-checking bench for the sensor two-wire port
`timescale 1ns/1ps
module tsense_port_bench;
    localparam logic [7:0] AW = {tsense_pkg::ADDR_BASE[6:3], 3'h5, 1'b0};
    localparam logic [7:0] AR = AW | 8'h01;

    logic            core_clk    = 1'b0;
    logic            resetn      = 1'b0;
    logic            pec_en      = 1'b0;
    logic            timeout_dis = 1'b0;
    logic [15:0]     temp_in     = 16'h0000;
    logic            temp_valid  = 1'b0;
    wire logic       scl;
    wire logic       pull;
    wire logic       sda_line;
    logic            sda_o;
    logic            sda_oe_n;
    logic [15:0]     rd_data;
    logic [15:0]     temp;
    logic [7:0]      sel;
    tsense_pkg::wr_t wr;
    logic            wr_stb;
    logic [24:0]     last_wr;
    logic [7:0]      crc;
    int              stb_cnt     = 0;
    int              miscompares = 0;
    int              checks      = 0;

    always #12.5 core_clk = ~core_clk;
    assign sda_line = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
    assign rd_data  = {8'ha5, sel};

    always @(posedge core_clk) begin
        if (wr_stb === 1'b1) begin
            stb_cnt++;
            last_wr = wr;
        end
    end

    tsense_port #(.ADDR_LOW(3'h5), .MS_CYCLES(10)) u_dut (
        .core_clk_i(core_clk), .resetn_i(resetn), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .pec_en_i(pec_en), .timeout_dis_i(timeout_dis), .temp_i(temp_in),
        .temp_valid_i(temp_valid), .rd_data_i(rd_data), .temp_o(temp),
        .sel_o(sel), .wr_o(wr), .wr_stb_o(wr_stb)
    );

    bus_master_model u_master (.scl_o(scl), .pull_o(pull), .sda_i(sda_line));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [24:0] got, input logic [24:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        u_master.write_byte(b, ack);
        check(25'(ack), 25'(exp_ack));
        crc = u_master.crc_next(crc, b);
    endtask

    task automatic open_write(input logic [7:0] s);
        crc = 8'h00;
        u_master.start();
        send(AW, 1'b1);
        send(s, 1'b1);
    endtask

    task automatic expect_wr(input int base, input int n,
                             input logic [24:0] w);
        repeat (8) @(negedge core_clk);
        check(25'(stb_cnt - base), 25'(n));
        if (n > 0) begin
            check(last_wr, w);
        end
    endtask

    task automatic pulse_temp(input logic [15:0] t);
        @(negedge core_clk);
        temp_in    = t;
        temp_valid = 1'b1;
        @(negedge core_clk);
        temp_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_freeze_read();
        logic [7:0] b;
        pulse_temp(16'h1940);
        repeat (2) @(negedge core_clk);
        check(25'(temp), 25'h1940);
        open_write(8'h00);
        u_master.start();
        send(AR, 1'b1);
        pulse_temp(16'h2a80);
        repeat (2) @(negedge core_clk);
        check(25'(temp), 25'h1940);
        u_master.read_byte(1'b1, b);
        check(25'(b), 25'h19);
        u_master.read_byte(1'b1, b);
        check(25'(b), 25'h40);
        u_master.read_byte(1'b0, b);
        check(25'(b), 25'h19);
        u_master.stop();
        repeat (4) @(negedge core_clk);
        check(25'(temp), 25'h2a80);
        $display("done freeze read");
    endtask

    task automatic test_timeout();
        timeout_dis = 1'b1;
        open_write(8'h00);
        u_master.start();
        send(AR, 1'b1);
        repeat (300) @(negedge core_clk);
        check(25'(sda_oe_n), 25'h0);
        check(25'(sda_o), 25'h0);
        timeout_dis = 1'b0;
        repeat (300) @(negedge core_clk);
        check(25'(sda_oe_n), 25'h1);
        u_master.stop();
        $display("done timeout");
    endtask

    task automatic test_plain_writes();
        int          base;
        logic [24:0] w;
        logic [7:0]  d [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
        for (int nb = 1; nb <= 4; nb = nb * 2) begin
            base = stb_cnt;
            open_write(8'h02);
            for (int i = 0; i < nb; i++) begin
                send(d[i], 1'b1);
            end
            u_master.stop();
            w = (nb == 1) ? {8'h02, d[0], 8'h00, 1'b1}
                          : {8'h02, d[nb-2], d[nb-1], 1'b0};
            expect_wr(base, 1, w);
            check(25'(sel), 25'h02);
        end
        $display("done plain writes");
    endtask

    task automatic test_foreign();
        int         base;
        logic [7:0] s;
        base = stb_cnt;
        s    = sel;
        u_master.start();
        send(AW ^ 8'h02, 1'b0);
        send(8'h01, 1'b0);
        u_master.stop();
        expect_wr(base, 0, 25'h0);
        check(25'(sel), 25'(s));
        $display("done foreign address");
    endtask

    task automatic test_pec_writes();
        int base;
        pec_en = 1'b1;
        base   = stb_cnt;
        open_write(8'h03);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        send(crc, 1'b1);
        send(8'h33, 1'b1);
        send(8'h44, 1'b1);
        send(crc, 1'b1);
        u_master.stop();
        expect_wr(base, 1, {8'h03, 16'h3344, 1'b0});
        base = stb_cnt;
        open_write(8'h03);
        send(8'h55, 1'b1);
        send(8'h66, 1'b1);
        u_master.stop();
        expect_wr(base, 0, 25'h0);
        open_write(8'h01);
        send(8'h55, 1'b1);
        send(8'h66, 1'b1);
        send(~crc, 1'b1);
        u_master.stop();
        expect_wr(base, 0, 25'h0);
        pec_en = 1'b0;
        $display("done pec writes");
    endtask

    task automatic test_pec_read();
        logic [7:0] b;
        pec_en = 1'b1;
        open_write(8'h02);
        u_master.start();
        send(AR, 1'b1);
        u_master.read_byte(1'b1, b);
        check(25'(b), 25'ha5);
        crc = u_master.crc_next(crc, 8'ha5);
        u_master.read_byte(1'b1, b);
        check(25'(b), 25'h02);
        crc = u_master.crc_next(crc, 8'h02);
        u_master.read_byte(1'b0, b);
        check(25'(b), 25'(crc));
        u_master.stop();
        pec_en = 1'b0;
        $display("done pec read");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #500_000;
        miscompares++;
        $display("Error at %0t: run hung", $time);
        conclude();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        test_freeze_read();
        test_timeout();
        test_plain_writes();
        test_foreign();
        test_pec_writes();
        test_pec_read();
        conclude();
    end
endmodule
